/* rtl/epi_regs.svh */
// register indices, field positions and reset values of the
// external pin interrupt unit; definitions only
`ifndef EPI_REGS_SVH
`define EPI_REGS_SVH

// register indices, byte address is four times the index
`define EPI_IDX_PC_MASK   6'h10
`define EPI_IDX_PC_FLAG   6'h11
`define EPI_IDX_PC_CTRL   6'h12
`define EPI_IDX_EXT_MASK  6'h13
`define EPI_IDX_EXT_FLAG  6'h14
`define EPI_IDX_EXT_SENSE 6'h15
`define EPI_IDX_EVT_STAT  6'h16
`define EPI_IDX_EVT_CLR   6'h17
`define EPI_IDX_EVT_EN    6'h18

// field positions
`define EPI_POS_ENABLE    0
`define EPI_POS_FLAG      0
`define EPI_POS_EVT_EXT   0
`define EPI_POS_EVT_PC    1

// reset values
`define EPI_RST_BYTE      8'h00
`define EPI_RST_MASK4     4'h0
`define EPI_RST_EVT       2'h0

`endif

/* rtl/epi_pkg.sv */
// types shared by the external pin interrupt unit
// assumes a classic wishbone slave with 32-bit data
package epi_pkg;

  // trigger select for the dedicated pin
  typedef enum logic [1:0] {
    EPI_SENSE_LOW  = 2'b00,
    EPI_SENSE_ANY  = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epiSense_e;

  // wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } epiWbReq_s;

  // wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } epiWbRsp_s;

endpackage

/* rtl/epi_unit.sv */
// external pin interrupt unit: dedicated pin plus four pin-change inputs
// assumes pins arrive as pad levels whatever their direction, and a core
// that supplies the global enable, the i/o clock state and acknowledges
//
// What this block does
// - pin activity raises enabled requests even when pins drive as outputs
// - any masked pin-change input toggling raises the single change request
// - pin-change detection works without the i/o clock, can wake device
// - sense code 00 low, 01 any change, 10 falling, 11 rising
// - low-level mode keeps requesting while the pin stays low
// - edge detection on the dedicated pin needs the i/o clock running
// - low-level detection needs no i/o clock and can wake the device
// - low level gone before wake-up: wake anyway, but no request
// - pin sampled before edge detect; pulses over one clock are caught
// - dedicated request forwarded only with its enable and global enable
// - trigger sets dedicated flag; cleared by handler entry or writing one
// - in low-level mode the dedicated flag always reads cleared
// - change request forwarded only with its enable and global enable
// - masked change sets change flag; cleared by handler entry or one
// - each of four mask bits gates change detection on its own pin
`timescale 1ns/1ps
`include "epi_regs.svh"

module epi_unit
  import epi_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // register bus
  input  wire epiWbReq_s  wbReq,
  output epiWbRsp_s       wbRsp,
  // pins
  input  wire logic       extIrqPin,
  input  wire logic [3:0] pinChangeInputs,
  // core side
  input  wire logic       globalIrqEnable,
  input  wire logic       ioClkRun,
  input  wire logic       extIrqAck,
  input  wire logic       pinChangeAck,
  output logic            extIrqReq,
  output logic            pinChangeRequest,
  output logic            wakeReq,
  // summary interrupt
  output logic            irq
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic        extMeta;
    logic        extSync;
    logic        extPrev;
    logic [3:0]  pcMeta;
    logic [3:0]  pcSync;
    logic [3:0]  pcPrev;
    epiSense_e   senseSel;
    logic        extEn;
    logic        pcEn;
    logic [3:0]  pcMask;
    logic        extFlag;
    logic        pcFlag;
    logic [1:0]  evtStatus;
    logic [1:0]  evtEnable;
    logic        ack;
    logic [31:0] rdData;
    logic        extReq;
    logic        pcReq;
    logic        wake;
    logic        irqOut;
  } epiState_s;

  epiState_s st_reg;
  epiState_s st_next;

  logic       levelMode;
  logic       extEdge;
  logic       pcChange;
  logic       wbHit;
  logic       wrEn;
  logic [7:0] wrByte;
  logic       extClr;
  logic       pcClr;
  logic [1:0] evtClr;
  logic [1:0] evtSet;

  // word index hit, shared by read and write decode
  function automatic logic hitIdx(input logic [7:0] adr,
                                  input logic [5:0] idx);
    hitIdx = (adr[7:2] == idx);
  endfunction

  // read mux, unmapped addresses read zero
  function automatic logic [31:0] readReg(input epiState_s s,
                                          input logic [7:0] adr);
    logic [7:0] b;
    b = 8'h00;
    if (hitIdx(adr, `EPI_IDX_PC_MASK))   b = {4'h0, s.pcMask};
    if (hitIdx(adr, `EPI_IDX_PC_FLAG))   b = {7'h00, s.pcFlag};
    if (hitIdx(adr, `EPI_IDX_PC_CTRL))   b = {7'h00, s.pcEn};
    if (hitIdx(adr, `EPI_IDX_EXT_MASK))  b = {7'h00, s.extEn};
    // level mode reads the flag clear from the first cycle the sense register
    // holds 00, one cycle before the flag register itself catches up
    if (hitIdx(adr, `EPI_IDX_EXT_FLAG))
      b = {7'h00, s.extFlag & (s.senseSel != EPI_SENSE_LOW)};
    if (hitIdx(adr, `EPI_IDX_EXT_SENSE)) b = {6'h00, s.senseSel};
    if (hitIdx(adr, `EPI_IDX_EVT_STAT))  b = {6'h00, s.evtStatus};
    if (hitIdx(adr, `EPI_IDX_EVT_EN))    b = {6'h00, s.evtEnable};
    readReg = {24'h00_0000, b};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    st_next = st_reg;

    // pad levels are sampled whatever the pin direction
    st_next.extMeta = extIrqPin;
    st_next.extSync = st_reg.extMeta;
    st_next.extPrev = st_reg.extSync;
    st_next.pcMeta  = pinChangeInputs;
    st_next.pcSync  = st_reg.pcMeta;
    st_next.pcPrev  = st_reg.pcSync;

    // trigger select for the dedicated pin
    levelMode = (st_reg.senseSel == EPI_SENSE_LOW);
    case (st_reg.senseSel)
      EPI_SENSE_LOW:  extEdge = 1'b0;
      EPI_SENSE_ANY:  extEdge = st_reg.extSync ^ st_reg.extPrev;
      EPI_SENSE_FALL: extEdge = st_reg.extPrev & ~st_reg.extSync;
      EPI_SENSE_RISE: extEdge = ~st_reg.extPrev & st_reg.extSync;
      default:        extEdge = 1'b0;
    endcase
    // edges seen while the i/o clock is stopped are dropped
    extEdge = extEdge & ioClkRun;

    // pin-change needs no i/o clock qualifier
    pcChange = |((st_reg.pcSync ^ st_reg.pcPrev) & st_reg.pcMask);

    // bus decode; writes land on the edge that sees ack high
    wbHit  = wbReq.cyc & wbReq.stb;
    wrEn   = wbHit & wbReq.we & st_reg.ack & wbReq.sel[0];
    wrByte = wbReq.dat[7:0];

    if (wrEn && hitIdx(wbReq.adr, `EPI_IDX_PC_MASK))
      st_next.pcMask = wrByte[3:0];
    if (wrEn && hitIdx(wbReq.adr, `EPI_IDX_PC_CTRL))
      st_next.pcEn = wrByte[`EPI_POS_ENABLE];
    if (wrEn && hitIdx(wbReq.adr, `EPI_IDX_EXT_MASK))
      st_next.extEn = wrByte[`EPI_POS_ENABLE];
    if (wrEn && hitIdx(wbReq.adr, `EPI_IDX_EXT_SENSE))
      st_next.senseSel = epiSense_e'(wrByte[1:0]);
    if (wrEn && hitIdx(wbReq.adr, `EPI_IDX_EVT_EN))
      st_next.evtEnable = wrByte[1:0];

    // write-one or acknowledge clears, a same-cycle trigger wins
    extClr = (wrEn & hitIdx(wbReq.adr, `EPI_IDX_EXT_FLAG)
              & wrByte[`EPI_POS_FLAG]) | extIrqAck;
    pcClr  = (wrEn & hitIdx(wbReq.adr, `EPI_IDX_PC_FLAG)
              & wrByte[`EPI_POS_FLAG]) | pinChangeAck;
    st_next.pcFlag = (st_reg.pcFlag & ~pcClr) | pcChange;
    if (levelMode)
      st_next.extFlag = 1'b0;
    else
      st_next.extFlag = (st_reg.extFlag & ~extClr) | extEdge;

    // level request follows the live pin, nothing is latched, so a
    // level gone before wake-up leaves no request behind
    st_next.extReq = globalIrqEnable & st_reg.extEn
                     & (levelMode ? ~st_reg.extSync : st_reg.extFlag);
    st_next.pcReq  = globalIrqEnable & st_reg.pcEn & st_reg.pcFlag;

    // wake works off paths that ignore the i/o clock
    st_next.wake = (st_reg.extEn & levelMode & ~st_reg.extSync)
                   | (st_reg.pcEn & pcChange);

    // sticky event status, set wins over a write-one clear
    evtSet = 2'b00;
    evtSet[`EPI_POS_EVT_EXT] = extEdge
                               | (levelMode & st_reg.extEn & ~st_reg.extSync);
    evtSet[`EPI_POS_EVT_PC]  = pcChange;
    evtClr = (wrEn && hitIdx(wbReq.adr, `EPI_IDX_EVT_CLR)) ? wrByte[1:0]
                                                            : 2'b00;
    st_next.evtStatus = (st_reg.evtStatus & ~evtClr) | evtSet;
    st_next.irqOut    = |(st_reg.evtStatus & st_reg.evtEnable);

    // one-cycle ack, dropped the cycle after so back to back is spaced
    st_next.ack    = wbHit & ~st_reg.ack;
    st_next.rdData = (wbHit & ~st_reg.ack) ? readReg(st_reg, wbReq.adr)
                                            : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  // reset loads constants only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.senseSel  <= EPI_SENSE_LOW;
      st_reg.pcMask    <= `EPI_RST_MASK4;
      st_reg.evtStatus <= `EPI_RST_EVT;
      st_reg.evtEnable <= `EPI_RST_EVT;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign wbRsp.ack        = st_reg.ack;
  assign wbRsp.dat        = st_reg.rdData;
  assign extIrqReq        = st_reg.extReq;
  assign pinChangeRequest = st_reg.pcReq;
  assign wakeReq          = st_reg.wake;
  assign irq              = st_reg.irqOut;

  ////////////////////////////////////////////////////////////////////
  // checks

  // every check runs on mclk and sleeps through reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_level_req_held: assert property (
    (st_reg.senseSel == EPI_SENSE_LOW && st_reg.extEn && globalIrqEnable
     && !st_reg.extSync) |=> extIrqReq)
    else $error("level request missing while pin low");

  a_level_flag_zero: assert property (
    st_reg.senseSel == EPI_SENSE_LOW |=> !st_reg.extFlag)
    else $error("flag set in level mode");

  a_ext_fwd_gate: assert property (
    extIrqReq |-> $past(globalIrqEnable) && $past(st_reg.extEn))
    else $error("dedicated request without enables");

  a_pc_fwd_gate: assert property (
    pinChangeRequest |-> $past(globalIrqEnable) && $past(st_reg.pcEn))
    else $error("change request without enables");

  a_pc_flag_set: assert property (
    (|((st_reg.pcSync ^ st_reg.pcPrev) & st_reg.pcMask)) |=> st_reg.pcFlag)
    else $error("masked change lost");

  a_mask_blocks: assert property (
    (st_reg.pcMask == 4'h0 && !st_reg.pcFlag) |=> !st_reg.pcFlag)
    else $error("flag set with all pins masked");

  a_edge_no_clk: assert property (
    (!ioClkRun && !st_reg.extFlag) |=> !st_reg.extFlag)
    else $error("edge taken without i/o clock");

  a_ack_clears: assert property (
    (extIrqAck && !extEdge) |=> !st_reg.extFlag)
    else $error("acknowledge did not clear flag");

  a_rise_latency: assert property (
    $rose(extIrqPin) ##0 (st_reg.senseSel == EPI_SENSE_RISE && ioClkRun
                          && !extIrqAck)[*3] |=> st_reg.extFlag)
    else $error("rising edge not flagged in three cycles");

  a_ack_one_cycle: assert property (
    wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held longer than one cycle");

  // dedicated pin forwarding and flag upkeep
  a_ext_fwd_set: assert property (
    (globalIrqEnable && st_reg.extEn && st_reg.extFlag
     && st_reg.senseSel != EPI_SENSE_LOW) |=> extIrqReq)
    else $error("dedicated request not forwarded");

  a_ext_gie_off: assert property (
    !globalIrqEnable |=> !extIrqReq)
    else $error("dedicated request with global enable low");

  a_ext_w1c: assert property (
    (wrEn && hitIdx(wbReq.adr, `EPI_IDX_EXT_FLAG)
     && wrByte[`EPI_POS_FLAG] && !extEdge) |=> !st_reg.extFlag)
    else $error("write one did not clear dedicated flag");

  a_ext_flag_hold: assert property (
    (st_reg.extFlag && !extIrqAck && !levelMode
     && !(wrEn && hitIdx(wbReq.adr, `EPI_IDX_EXT_FLAG)))
    |=> st_reg.extFlag)
    else $error("dedicated flag lost without a clear");

  a_ext_evt_set: assert property (
    extEdge |=> st_reg.evtStatus[`EPI_POS_EVT_EXT])
    else $error("dedicated event not recorded");

  a_fall_latency: assert property (
    $fell(extIrqPin) ##0 (st_reg.senseSel == EPI_SENSE_FALL && ioClkRun
                          && !extIrqAck)[*3] |=> st_reg.extFlag)
    else $error("falling edge not flagged in three cycles");

  a_any_latency: assert property (
    $changed(extIrqPin) ##0 (st_reg.senseSel == EPI_SENSE_ANY && ioClkRun
                             && !extIrqAck)[*3] |=> st_reg.extFlag)
    else $error("pin change not flagged in three cycles");

  // low level path needs no i/o clock and latches nothing
  a_level_gone: assert property (
    (levelMode && st_reg.extSync) |=> !extIrqReq)
    else $error("level request left after pin rose");

  a_wake_level: assert property (
    (st_reg.extEn && levelMode && !st_reg.extSync) |=> wakeReq)
    else $error("low level did not request wake");

  // pin-change forwarding, clears and masking
  a_pc_fwd_set: assert property (
    (globalIrqEnable && st_reg.pcEn && st_reg.pcFlag) |=> pinChangeRequest)
    else $error("change request not forwarded");

  a_pc_gie_off: assert property (
    !globalIrqEnable |=> !pinChangeRequest)
    else $error("change request with global enable low");

  a_pc_ack_clears: assert property (
    (pinChangeAck && !pcChange) |=> !st_reg.pcFlag)
    else $error("acknowledge did not clear change flag");

  a_pc_w1c: assert property (
    (wrEn && hitIdx(wbReq.adr, `EPI_IDX_PC_FLAG)
     && wrByte[`EPI_POS_FLAG] && !pcChange) |=> !st_reg.pcFlag)
    else $error("write one did not clear change flag");

  a_pc_flag_hold: assert property (
    (st_reg.pcFlag && !pinChangeAck
     && !(wrEn && hitIdx(wbReq.adr, `EPI_IDX_PC_FLAG)))
    |=> st_reg.pcFlag)
    else $error("change flag lost without a clear");

  a_pc_mask_gate: assert property (
    (((st_reg.pcSync ^ st_reg.pcPrev) & st_reg.pcMask) == 4'h0
     && !st_reg.pcFlag) |=> !st_reg.pcFlag)
    else $error("change flag set by a masked pin");

  a_pc_evt_set: assert property (
    pcChange |=> st_reg.evtStatus[`EPI_POS_EVT_PC])
    else $error("change event not recorded");

  a_wake_change: assert property (
    (st_reg.pcEn && pcChange) |=> wakeReq)
    else $error("pin change did not request wake");

  // summary interrupt and bus answer
  a_irq_follows: assert property (
    (|(st_reg.evtStatus & st_reg.evtEnable)) |=> irq)
    else $error("summary interrupt missing");

  a_irq_quiet: assert property (
    !(|(st_reg.evtStatus & st_reg.evtEnable)) |=> !irq)
    else $error("summary interrupt without enabled event");

  a_ack_answers: assert property (
    (wbReq.cyc && wbReq.stb && !wbRsp.ack) |=> wbRsp.ack)
    else $error("bus request left without ack");

  a_rd_zero_idle: assert property (
    !wbRsp.ack |-> wbRsp.dat == 32'h0000_0000)
    else $error("read data shown outside ack");

  c_ext_flag: cover property ($rose(st_reg.extFlag));
  c_pc_req: cover property ($rose(pinChangeRequest));
  c_level_req: cover property (levelMode && extIrqReq);
  c_bus_write: cover property (wrEn);
  c_ext_ack: cover property (extIrqAck && st_reg.extFlag);

endmodule

/* tb/epi_core_model.sv */
// core model: enters vectors by pulsing the acknowledges
// assumes requests already carry the global enable
`timescale 1ns/1ps

module epi_core_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // vector entry switch and requests
  input  wire logic autoAck,
  input  wire logic extIrqReq,
  input  wire logic pinChangeRequest,
  // acknowledges
  output logic      extIrqAck,
  output logic      pinChangeAck
);
  //////////////////////////////////////////////////////////////////////////
  // the request stays up two cycles after an ack while the flag drains
  logic extHold;
  logic pcHold;

  // one-cycle ack, then two quiet cycles so a stale request is not re-entered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      extIrqAck    <= 1'b0;
      pinChangeAck <= 1'b0;
      extHold      <= 1'b0;
      pcHold       <= 1'b0;
    end else begin
      extIrqAck    <= autoAck & extIrqReq & ~extIrqAck & ~extHold;
      pinChangeAck <= autoAck & pinChangeRequest & ~pinChangeAck & ~pcHold;
      extHold      <= extIrqAck;
      pcHold       <= pinChangeAck;
    end
  end
endmodule

/* tb/testbench.sv */
// self-checking bench for the external pin interrupt unit
// assumes 40 MHz mclk and the core model beside the unit
`timescale 1ns/1ps

module testbench
  import epi_pkg::*;
;
  // stimulus and observed signals
  logic       mclk    = 1'b0;
  logic       rst     = 1'b1;
  logic       gie     = 1'b1;
  logic       ioRun   = 1'b1;
  logic       autoAck = 1'b0;
  logic       extPin  = 1'b1;
  logic [3:0] pcIn    = 4'h0;
  epiWbReq_s  wbReq   = '0;
  epiWbRsp_s  wbRsp;
  logic       extAck, pcAck, extReq, pcReq, wake, irq;
  int         badCount = 0;
  int         nChecks  = 0;

  always #12.5 mclk = ~mclk;

  epi_unit dut_u (.mclk(mclk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
    .extIrqPin(extPin), .pinChangeInputs(pcIn), .globalIrqEnable(gie),
    .ioClkRun(ioRun), .extIrqAck(extAck), .pinChangeAck(pcAck),
    .extIrqReq(extReq), .pinChangeRequest(pcReq), .wakeReq(wake),
    .irq(irq));
  epi_core_model core_u (.mclk(mclk), .rst(rst), .autoAck(autoAck),
    .extIrqReq(extReq), .pinChangeRequest(pcReq), .extIrqAck(extAck),
    .pinChangeAck(pcAck));

  ////////////////////////////////////////////////////////////////////////////
  // compare, report and end
  task automatic chk(input string nm, input logic [7:0] got, exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // classic cycle; ack and data read as sampled at the rising edge,
  // request released by that same edge, idle a cycle before the next
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    int n = 0;
    @(posedge mclk);
    wbReq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h00_0000, d}};
    do begin
      @(posedge mclk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 8'h00, 8'h01);
    q = wbRsp.dat[7:0];
    wbReq <= '0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, q, exp);
  endtask
  // pins held six cycles: covers sync, flag and request latency
  task automatic pins(input logic e, input logic [3:0] p);
    @(posedge mclk);
    extPin <= e;
    pcIn   <= p;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 9; i++)
      rd("rstVal", 8'h40 + 8'(4 * i), 8'h00);
    wr(8'h40, 8'hFF);
    rd("mask", 8'h40, 8'h0F);
    wr(8'h54, 8'hFF);
    rd("sense", 8'h54, 8'h03);
    wr(8'h80, 8'h55);
    rd("unmapped", 8'h80, 8'h00);
  endtask
  task automatic t_modes();
    wr(8'h4C, 8'h01);
    for (int c = 1; c < 4; c++) begin
      wr(8'h54, 8'(c));
      pins(1'b0, 4'h0);
      wr(8'h50, 8'h01);
      pins(1'b1, 4'h0);
      rd("riseFlag", 8'h50, {7'h00, c[0]});
      wr(8'h50, 8'h01);
      pins(1'b0, 4'h0);
      rd("fallFlag", 8'h50, {7'h00, c != 3});
    end
  endtask
  task automatic t_pulse();
    wr(8'h50, 8'h01);
    @(posedge mclk) extPin <= 1'b1;
    repeat (2) @(posedge mclk);
    extPin <= 1'b0;
    pins(1'b0, 4'h0);
    chk("reqOn", {7'h00, extReq}, 8'h01);
    @(posedge mclk) gie <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("reqGated", {7'h00, extReq}, 8'h00);
    rd("pulseFlag", 8'h50, 8'h01);
    wr(8'h50, 8'h01);
    @(posedge mclk) ioRun <= 1'b0;
    pins(1'b1, 4'h0);
    rd("noClkFlag", 8'h50, 8'h00);
  endtask
  task automatic t_level();
    @(posedge mclk) gie <= 1'b1;
    wr(8'h54, 8'h00);
    pins(1'b0, 4'h0); // low held well past one access
    chk("lvlReq", {7'h00, extReq}, 8'h01);
    chk("lvlWake", {7'h00, wake}, 8'h01);
    rd("lvlFlag", 8'h50, 8'h00);
    pins(1'b1, 4'h0);
    chk("lvlGone", {7'h00, extReq}, 8'h00);
  endtask
  task automatic t_change();
    wr(8'h48, 8'h01);
    wr(8'h40, 8'h04);
    pins(1'b1, 4'h2);
    rd("maskedOut", 8'h44, 8'h00);
    pins(1'b1, 4'h6);
    rd("pcFlag", 8'h44, 8'h01);
    chk("pcReq", {7'h00, pcReq}, 8'h01);
    @(posedge mclk) gie <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("pcGated", {7'h00, pcReq}, 8'h00);
    wr(8'h44, 8'h01);
    rd("pcClr", 8'h44, 8'h00);
    @(posedge mclk) gie <= 1'b1;
    autoAck <= 1'b1;
    pins(1'b1, 4'h2);
    rd("ackClr", 8'h44, 8'h00);
    @(posedge mclk) autoAck <= 1'b0;
  endtask
  task automatic t_irq();
    wr(8'h5C, 8'h03);
    rd("statClr", 8'h58, 8'h00);
    wr(8'h60, 8'h02);
    pins(1'b1, 4'h6);
    rd("stat", 8'h58, 8'h02);
    chk("irqOn", {7'h00, irq}, 8'h01);
    wr(8'h60, 8'h00);
    repeat (2) @(negedge mclk);
    chk("irqMasked", {7'h00, irq}, 8'h00);
    wr(8'h5C, 8'h02);
    wr(8'h60, 8'h02);
    repeat (2) @(negedge mclk);
    chk("irqClr", {7'h00, irq}, 8'h00);
  endtask
  // core enters the dedicated vector: its ack alone clears the flag
  task automatic t_ack();
    @(posedge mclk) ioRun <= 1'b1;
    wr(8'h54, 8'h03);
    pins(1'b0, 4'h6);
    @(posedge mclk) autoAck <= 1'b1;
    pins(1'b1, 4'h6);
    @(posedge mclk) autoAck <= 1'b0;
    rd("extAckClr", 8'h50, 8'h00);
    rd("extAckStat", 8'h58, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence, then a watchdog against hangs
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_pulse();
    t_level();
    t_change();
    t_irq();
    t_ack();
    wrapUp();
  end
  initial begin
    repeat (4000) @(posedge mclk);
    badCount++;
    wrapUp();
  end
endmodule
